// *** core/wdg_windowed_watchdog.sv ***
// Windowed watchdog: down-counter, halt handling, reset pulse and APB registers
//
// What this block does
// - Maximum timeout is base plus 16384 per count, or stepped form above quarter constant.
// - Divisions in the timeout formulas truncate before further arithmetic.
// - Slow and wait modes leave counting and resetting unchanged.
// - Plain halt without reset option decrements once, then freezes and cannot reset.
// - After external wake from plain halt, counting resumes after 256 or 4096 clocks.
// - Plain halt ended by reset comes up disabled unless hardware watchdog is forced.
// - Halt with reset option and no timebase interrupt resets at once.
// - Halt with timebase interrupt enabled stops the counter; any wake resumes at once.
// - Active-halt ended by reset resumes counting after 256 or 4096 clocks.
// - Hardware option keeps the watchdog active, activation bit then irrelevant.
// - Control register resets to 7Fh: activation clear, counter all ones.
// - Activation bit set by writing one; only reset clears it.
// - Watchdog resets only while activated or hardware forced, except halt with reset option and no timebase interrupt, which resets regardless.
// - Seven-bit counter is read-write and decrements every 16384 oscillator cycles.
// - When active, counter passing 40h to 3Fh issues a reset.
// - Counter decrements even when the watchdog is not activated.
// - Write setting activation with top counter bit clear resets immediately.
// - Watchdog reset drives the reset line low for about 500 ns.
`timescale 1ns/1ps
module wdg_windowed_watchdog
  import wdg_pkg::*;
#(
  parameter int unsigned PRESC_DIV = PRESC_DEFAULT
)
(
  input  wire logic              clk,
  input  wire logic              resetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [APB_AW-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              mcu_reset,
  input  wire logic              halt_req,
  input  wire logic              ext_irq_wake,
  input  wire logic              osc_irq_wake,
  input  wire logic              timebase_irq_enable,
  input  wire logic [1:0]        timebase_select,
  input  wire logic              halt_reset_option,
  input  wire logic              hw_watchdog_option,
  input  wire logic              wake_delay_long,
  output logic                   wdg_reset_n,
  output logic      [6:0]        timeout_count
);

  // All control inputs come from CPU-clock logic, so they are used without synchronisers

  wdg_ctrl_s  ctrl;
  wdg_state_e state;
  wdg_tout_s  tout;
  logic [13:0] presc;
  logic [11:0] delay;
  logic [4:0]  pulse_cnt;

  logic       counting;
  logic       tick;
  logic       active;
  logic       apb_wr;
  logic       mapped;
  logic       wr_ctrl;
  logic       act_after;
  logic       fire_count;
  logic       fire_write;
  logic       fire_halt;
  logic       fire;
  logic       halt_plain;
  logic       halt_active;
  logic [31:0] next_rdata;
  logic [11:0] delay_load;

  // Decode

  assign mapped = (paddr == ADDR_CTRL) || (paddr == ADDR_TMAX)
               || (paddr == ADDR_TMIN) || (paddr == ADDR_STAT);
  assign apb_wr  = psel && penable && pready && pwrite;
  assign wr_ctrl = apb_wr && (paddr == ADDR_CTRL);

  // Activity and counting

  assign active = ctrl.activate || hw_watchdog_option;

  // Slow and wait are invisible here: only the frozen and active-halt states and the restart delay stop the count
  assign counting = (state == WS_RUN) || (state == WS_HPEND);
  assign tick     = counting && (presc == 14'(PRESC_DIV - 1));

  assign delay_load = wake_delay_long ? 12'(WAKE_LONG - 1) : 12'(WAKE_SHORT - 1);

  // Halt decisions

  assign halt_active = halt_req && (state == WS_RUN) && timebase_irq_enable;
  assign halt_plain  = halt_req && (state == WS_RUN) && !timebase_irq_enable
                    && !halt_reset_option;
  assign fire_halt   = halt_req && (state == WS_RUN) && !timebase_irq_enable
                    && halt_reset_option;

  // Reset causes

  assign fire_count = tick && !wr_ctrl && (state == WS_RUN) && active
                   && (ctrl.count == CNT_TRIP);
  assign act_after  = ctrl.activate || pwdata[ACT_BIT] || hw_watchdog_option;
  assign fire_write = wr_ctrl && act_after && !pwdata[TOP_BIT];
  assign fire       = (fire_count || fire_write || fire_halt) && !mcu_reset;

  // Prescaler: held in the frozen, active-halt and restart-delay states so the count freezes with it

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      presc <= '0;
    else if (mcu_reset)
      presc <= '0;
    else if (tick)
      presc <= '0;
    else if (counting)
      presc <= presc + 14'd1;
  end

  // Control register

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      ctrl <= wdg_ctrl_s'(CTRL_RESET);
    else if (mcu_reset)
      ctrl <= wdg_ctrl_s'(CTRL_RESET);
    else
    begin
      if (wr_ctrl)
      begin
        // Writing zero leaves activation alone
        ctrl.activate <= ctrl.activate || pwdata[ACT_BIT];
        ctrl.count    <= pwdata[6:0];
      end
      else if (tick)
        ctrl.count <= ctrl.count - 7'd1;
    end
  end

  assign timeout_count = ctrl.count;

  // Low-power state machine

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      state <= WS_RUN;
    else if (mcu_reset)
    begin
      // Only active-halt remembers across a system reset and delays the restart
      if (state == WS_AHALT)
        state <= WS_RESUME;
      else
        state <= WS_RUN;
    end
    else
    begin
      unique case (state)
        WS_RUN:
        begin
          if (halt_active)
            state <= WS_AHALT;
          else if (halt_plain)
            state <= WS_HPEND;
        end
        WS_HPEND:
        begin
          // One more step is taken, then the count stops
          if (ext_irq_wake)
            state <= WS_RESUME;
          else if (tick)
            state <= WS_FROZEN;
        end
        WS_FROZEN:
        begin
          if (ext_irq_wake)
            state <= WS_RESUME;
        end
        WS_AHALT:
        begin
          if (ext_irq_wake || osc_irq_wake)
            state <= WS_RUN;
        end
        WS_RESUME:
        begin
          if (delay == '0)
            state <= WS_RUN;
        end
      endcase
    end
  end

  // Restart delay

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      delay <= '0;
    else if (mcu_reset && (state == WS_AHALT))
      delay <= delay_load;
    else if (!mcu_reset && ext_irq_wake && ((state == WS_HPEND) || (state == WS_FROZEN)))
      delay <= delay_load;
    else if ((state == WS_RESUME) && (delay != '0))
      delay <= delay - 12'd1;
  end

  // Reset pulse toward the reset circuitry

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      pulse_cnt   <= '0;
      wdg_reset_n <= 1'b1;
    end
    else if (fire)
    begin
      pulse_cnt   <= 5'(RST_PULSE_CYC);
      wdg_reset_n <= 1'b0;
    end
    else if (pulse_cnt != '0)
    begin
      pulse_cnt   <= pulse_cnt - 5'd1;
      wdg_reset_n <= (pulse_cnt == 5'd1);
    end
  end

  // Timeout figures for software

  wdg_timeout_calc u_calc
  (
    .clk             (clk),
    .resetn          (resetn),
    .cnt             (ctrl.count[5:0]),
    .timebase_select (timebase_select),
    .tout            (tout)
  );

  // APB read mux

  always_comb
  begin
    next_rdata = '0;
    if (paddr == ADDR_CTRL)
      next_rdata = {24'h000000, ctrl};
    else if (paddr == ADDR_TMAX)
      next_rdata = {8'h00, tout.tmax};
    else if (paddr == ADDR_TMIN)
      next_rdata = {8'h00, tout.tmin};
    else if (paddr == ADDR_STAT)
      next_rdata = {24'h000000, 1'b0, hw_watchdog_option, active, state};
  end

  // APB answer: one access cycle, no wait states

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= '0;
    end
    else if (psel && !penable)
    begin
      pready  <= 1'b1;
      pslverr <= !mapped;
      prdata  <= pwrite ? 32'h00000000 : next_rdata;
    end
    else
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= '0;
    end
  end

endmodule : wdg_windowed_watchdog

// *** core/wdg_pkg.sv ***
// Shared constants, types and register map of the windowed watchdog
package wdg_pkg;

  // Register map: the control register index is not word aligned, so bytes sit at index times four
  localparam logic [7:0] CTRL_IDX   = 8'h2A;
  localparam int         APB_AW     = 10;
  localparam logic [9:0] ADDR_CTRL  = {CTRL_IDX, 2'b00};
  localparam logic [9:0] ADDR_TMAX  = 10'h0AC;
  localparam logic [9:0] ADDR_TMIN  = 10'h0B0;
  localparam logic [9:0] ADDR_STAT  = 10'h0B4;

  // Control register layout and value after reset
  localparam int         ACT_BIT    = 7;
  localparam int         TOP_BIT    = 6;
  localparam logic [7:0] CTRL_RESET = 8'h7F;
  localparam logic [6:0] CNT_TRIP   = 7'h40;

  // Oscillator periods per count step, also the prescaler length, and the timeout formula constants
  localparam int unsigned PRESC_DEFAULT = 16384;
  localparam int unsigned PER_COUNT     = 16384;
  localparam int unsigned STEP_BASE     = 192;
  localparam int unsigned STEP_MULT     = 64;
  localparam int unsigned TMIN0_ADD     = 128;

  // Timing at the 40 MHz clock
  localparam int unsigned CLK_MHZ       = 40;
  localparam int unsigned RST_PULSE_NS  = 500;
  localparam int unsigned RST_PULSE_CYC = RST_PULSE_NS * CLK_MHZ / 1000;
  localparam int unsigned WAKE_SHORT    = 256;
  localparam int unsigned WAKE_LONG     = 4096;

  typedef struct packed {
    logic       activate;
    logic [6:0] count;
  } wdg_ctrl_s;

  typedef struct packed {
    logic [23:0] tmin;
    logic [23:0] tmax;
  } wdg_tout_s;

  typedef enum logic [4:0] {
    WS_RUN    = 5'b00001,
    WS_HPEND  = 5'b00010,
    WS_FROZEN = 5'b00100,
    WS_AHALT  = 5'b01000,
    WS_RESUME = 5'b10000
  } wdg_state_e;

endpackage : wdg_pkg

// *** core/wdg_timeout_calc.sv ***
// Exact minimum and maximum timeout, in oscillator periods, for the loaded count
`timescale 1ns/1ps
module wdg_timeout_calc
  import wdg_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       resetn,
  input  wire logic [5:0] cnt,
  input  wire logic [1:0] timebase_select,
  output wdg_tout_s       tout
);

  logic [5:0]  msb;
  logic [5:0]  lsb;
  logic [7:0]  q;
  logic [23:0] body;
  logic [23:0] lin;
  logic [23:0] tmin0;
  logic [23:0] next_tmin;
  logic [23:0] next_tmax;

  always_comb
  begin
    unique case (timebase_select)
      2'b00:
      begin
        msb = 6'd4;
        lsb = 6'd59;
      end
      2'b01:
      begin
        msb = 6'd8;
        lsb = 6'd53;
      end
      2'b10:
      begin
        msb = 6'd20;
        lsb = 6'd35;
      end
      2'b11:
      begin
        msb = 6'd49;
        lsb = 6'd54;
      end
    endcase
    // Integer division truncates, as the formulas require
    q     = 8'(({2'b00, cnt} * 8'd4) / {2'b00, msb});
    lin   = 24'(PER_COUNT) * 24'(cnt);
    body  = 24'(PER_COUNT) * (24'(cnt) - 24'(q))
          + (24'(STEP_BASE) + 24'(lsb)) * 24'(STEP_MULT) * 24'(q);
    tmin0 = (24'(lsb) + 24'(TMIN0_ADD)) * 24'(STEP_MULT);
    next_tmax = 24'(PER_COUNT) + ((cnt <= (msb >> 2)) ? lin : body);
    next_tmin = tmin0 + ((cnt < (msb >> 2)) ? lin : body);
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      tout <= '0;
    else
      tout <= '{tmin: next_tmin, tmax: next_tmax};
  end

endmodule : wdg_timeout_calc

// *** bench/wdg_windowed_watchdog_props.sv ***
// Port-level checks for the windowed watchdog
`timescale 1ns/1ps
module wdg_windowed_watchdog_props
  import wdg_pkg::*;
(
  input wire logic              clk,
  input wire logic              resetn,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [APB_AW-1:0] paddr,
  input wire logic [31:0]       pwdata,
  input wire logic [31:0]       prdata,
  input wire logic              pready,
  input wire logic              mcu_reset,
  input wire logic              halt_req,
  input wire logic              hw_watchdog_option,
  input wire logic              wdg_reset_n,
  input wire logic [6:0]        timeout_count
);
  logic wr_ctrl;
  logic act_seen;
  assign wr_ctrl = psel && penable && pready && pwrite && (paddr == ADDR_CTRL);
  // Shadow of the activation bit: a write of zero must never clear it
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      act_seen <= 1'b0;
    else if (mcu_reset)
      act_seen <= 1'b0;
    else if (wr_ctrl && pwdata[ACT_BIT])
      act_seen <= 1'b1;
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);
  sequence s_low_hold;
    (!wdg_reset_n) [*8] ##1 (!wdg_reset_n) [*8] ##1 (!wdg_reset_n) [*4] ##1 wdg_reset_n;
  endsequence
  a_reset_value: assert property ($rose(resetn) |-> timeout_count == CTRL_RESET[6:0])
    else $error("count not at reset value");
  a_pulse_width: assert property ($fell(wdg_reset_n) |-> s_low_hold)
    else $error("reset pulse length wrong");
  a_soft_reset: assert property (wr_ctrl && !pwdata[TOP_BIT] && (act_seen || pwdata[ACT_BIT]) && !mcu_reset
    |=> !wdg_reset_n) else $error("software reset missing");
  a_count_trip: assert property ($past(timeout_count) == CNT_TRIP && timeout_count == 7'h3F && act_seen
    && !$past(mcu_reset) |-> !wdg_reset_n) else $error("no reset at count trip");
  a_quiet_idle: assert property ($fell(wdg_reset_n)
    |-> $past(act_seen) || $past(hw_watchdog_option) || $past(halt_req)
    || ($past(wr_ctrl) && $past(pwdata[ACT_BIT])))
    else $error("reset while inactive");
  a_count_step: assert property (timeout_count != $past(timeout_count) && !$past(wr_ctrl)
    && !$past(mcu_reset) |-> timeout_count == $past(timeout_count) - 7'h01) else $error("bad count step");
  a_count_load: assert property (wr_ctrl && !mcu_reset |=> timeout_count == $past(pwdata[6:0]))
    else $error("count not loaded");
  a_read_back: assert property (psel && penable && pready && !pwrite && paddr == ADDR_CTRL
    |-> prdata[6:0] == $past(timeout_count) && prdata[31:8] == 24'h000000) else $error("bad read");
endmodule : wdg_windowed_watchdog_props
bind wdg_windowed_watchdog wdg_windowed_watchdog_props u_wdg_windowed_watchdog_props (.clk, .resetn, .psel,
  .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .mcu_reset, .halt_req, .hw_watchdog_option,
  .wdg_reset_n, .timeout_count);

// *** bench/wdg_rst_model.sv ***
// Reset circuitry model: one cycle of system reset at the end of each watchdog pulse
`timescale 1ns/1ps
module wdg_rst_model
(
  input  wire logic clk,
  input  wire logic resetn,
  input  wire logic wdg_reset_n,
  output logic      mcu_reset
);
  logic prev_n;
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      prev_n <= 1'b1;
    else
      prev_n <= wdg_reset_n;
  end
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      mcu_reset <= 1'b0;
    else
      mcu_reset <= wdg_reset_n && !prev_n;
  end
endmodule : wdg_rst_model

// *** bench/wdg_windowed_watchdog_test.sv ***
// Self-checking bench for the windowed watchdog
`timescale 1ns/1ps
module wdg_windowed_watchdog_test
  import wdg_pkg::*;
;
  // Count at which the maximum timeout formula switches, per timebase
  localparam int QB [4] = '{1, 2, 5, 12};
  logic        clk, resetn, psel, penable, pwrite, pready, pslverr, err, halt_req, ext_w, osc_w;
  logic        tie, hro, hw, wdl, wdg_reset_n, mcu_reset;
  logic [1:0]  tbs;
  logic [9:0]  paddr;
  logic [31:0] pwdata, prdata, r;
  logic [6:0]  cnt, c1;
  logic [7:0]  lf;
  int          n_mismatch, comparisons, cyc, npulse, lowc, plen, np, c;
  always #12.5 clk = ~clk;
  wdg_windowed_watchdog #(.PRESC_DIV(16)) u_wdg_windowed_watchdog (.clk, .resetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .mcu_reset, .halt_req, .ext_irq_wake(ext_w),
    .osc_irq_wake(osc_w), .timebase_irq_enable(tie), .timebase_select(tbs), .halt_reset_option(hro),
    .hw_watchdog_option(hw), .wake_delay_long(wdl), .wdg_reset_n, .timeout_count(cnt));
  wdg_rst_model u_wdg_rst_model (.clk, .resetn, .wdg_reset_n, .mcu_reset);
  function automatic logic [7:0] f_lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : f_lfsr
  // Minimum uses a strict compare and its own base; maximum a non-strict one
  function automatic logic [31:0] f_tout(input int n, input int t, input bit mn);
    int m, l, k, b;
    m = (t == 0) ? 4 : (t == 1) ? 8 : (t == 2) ? 20 : 49;
    l = (t == 0) ? 59 : (t == 1) ? 53 : (t == 2) ? 35 : 54;
    k = 4 * n / m;
    b = mn ? (l + TMIN0_ADD) * STEP_MULT : PER_COUNT;
    if (mn ? (n < m / 4) : (n <= m / 4))
      return b + PER_COUNT * n;
    return b + PER_COUNT * (n - k) + (STEP_BASE + l) * STEP_MULT * k;
  endfunction : f_tout
  task give_verdict();
    $display("checks %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : give_verdict
  task chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task apb(input logic w, input logic [9:0] a, input logic [31:0] d);
    @(posedge clk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1)
      @(posedge clk);
    r = prdata;
    err = pslverr;
    {psel, penable} <= 2'b00;
  endtask : apb
  // Aligning to a count step keeps the prescaler phase known afterwards
  task load(input logic [7:0] v);
    c1 = cnt;
    while (cnt === c1)
      @(posedge clk);
    apb(1'b1, ADDR_CTRL, {24'h000000, v});
  endtask : load
  task strobe(input int k);
    @(posedge clk);
    {halt_req, ext_w, osc_w} <= {k == 0, k == 1, k == 2};
    @(posedge clk);
    {halt_req, ext_w, osc_w} <= 3'b000;
  endtask : strobe
  always @(posedge clk)
  begin
    cyc = cyc + 1;
    if (wdg_reset_n === 1'b0)
      lowc = lowc + 1;
    else if (lowc != 0)
    begin
      plen = lowc;
      lowc = 0;
      npulse = npulse + 1;
    end
    if (cyc == 20000)
    begin
      n_mismatch++;
      give_verdict();
    end
  end
  initial
  begin
    {clk, resetn, psel, penable, pwrite, halt_req, ext_w, osc_w, tie, hro, hw, wdl} = 12'h000;
    {tbs, paddr, pwdata, lf} = {44'h0, 8'h51};
    repeat (12) @(posedge clk);
    resetn <= 1'b1;
    apb(1'b0, ADDR_CTRL, 32'h0);
    chk(r, 32'h0000007F);
    apb(1'b0, 10'h3FC, 32'h0);
    chk({31'h0, err}, 32'h1);
    for (int t = 0; t < 4; t++)
      for (int j = 0; j < 4; j++)
      begin
        lf = f_lfsr(lf);
        tbs <= t[1:0];
        c = (j == 0) ? QB[t] : (j == 1) ? QB[t] + 1 : (j == 2) ? 63 : int'(lf[5:0]);
        load({2'b01, c[5:0]});
        apb(1'b0, ADDR_CTRL, 32'h0);
        chk(r, {25'h0, 1'b1, c[5:0]});
        apb(1'b0, ADDR_TMAX, 32'h0);
        chk(r, f_tout(c, t, 1'b0));
        apb(1'b0, ADDR_TMIN, 32'h0);
        chk(r, f_tout(c, t, 1'b1));
      end
    $display("test timeout table done");
    for (int j = 0; j < 3; j++)
    begin
      lf = f_lfsr(lf);
      np = npulse;
      c = (j == 0) ? 1 : int'(lf[5:0]);
      load({2'b01, c[5:0]});
      repeat (66) @(posedge clk);
      chk(cnt, 32'h40 + c - 4);
      chk(npulse, np);
    end
    apb(1'b1, ADDR_CTRL, 32'hFF);
    apb(1'b1, ADDR_CTRL, 32'h7F);
    apb(1'b0, ADDR_CTRL, 32'h0);
    chk(r[7], 32'h1);
    np = npulse;
    apb(1'b1, ADDR_CTRL, 32'h3F);
    repeat (30) @(posedge clk);
    chk(npulse, np + 1);
    chk(plen, RST_PULSE_CYC);
    apb(1'b0, ADDR_CTRL, 32'h0);
    chk(r[7], 32'h0);
    load(8'hC1);
    repeat (60) @(posedge clk);
    chk(npulse, np + 2);
    hw <= 1'b1;
    load(8'h41);
    repeat (60) @(posedge clk);
    chk(npulse, np + 3);
    hw <= 1'b0;
    hro <= 1'b1;
    strobe(0);
    repeat (30) @(posedge clk);
    chk(npulse, np + 4);
    hro <= 1'b0;
    $display("test resets done");
    for (int d = 0; d < 2; d++)
    begin
      wdl <= d[0];
      load(8'h7F);
      strobe(0);
      repeat (120) @(posedge clk);
      chk(cnt, 32'h7E);
      strobe(1);
      repeat ((d == 1 ? WAKE_LONG : WAKE_SHORT) - 40) @(posedge clk);
      chk(cnt, 32'h7E);
      repeat (80) @(posedge clk);
      chk({31'h0, cnt < 7'h7E}, 32'h1);
    end
    tie <= 1'b1;
    for (int k = 1; k < 3; k++)
    begin
      hro <= (k == 2);
      load(8'h7F);
      strobe(0);
      repeat (100) @(posedge clk);
      chk(cnt, 32'h7F);
      strobe(k);
      repeat (40) @(posedge clk);
      chk({31'h0, cnt < 7'h7F}, 32'h1);
    end
    // Reset during active-halt: counting restarts only after the wake delay
    np = npulse;
    wdl <= 1'b0;
    load(8'h7F);
    strobe(0);
    apb(1'b1, ADDR_CTRL, 32'hBF);
    repeat (60) @(posedge clk);
    apb(1'b0, ADDR_STAT, 32'h0);
    chk(r, 32'h00000010);
    repeat (180) @(posedge clk);
    chk(cnt, 32'h7F);
    repeat (80) @(posedge clk);
    chk({31'h0, cnt < 7'h7F}, 32'h1);
    chk(npulse, np + 1);
    // Reset ending a plain halt leaves the watchdog disabled and running
    tie <= 1'b0;
    hro <= 1'b0;
    load(8'hFF);
    strobe(0);
    repeat (30) @(posedge clk);
    apb(1'b1, ADDR_CTRL, 32'hBF);
    repeat (30) @(posedge clk);
    apb(1'b0, ADDR_CTRL, 32'h0);
    chk(r, 32'h0000007F);
    apb(1'b0, ADDR_STAT, 32'h0);
    chk(r, 32'h00000001);
    $display("test halt modes done");
    give_verdict();
  end
endmodule : wdg_windowed_watchdog_test
